// ==== core/sssp_top.sv ====
// Supervisor: processor reset, watchdog, SRAM select gating, interrupt pin and 3-wire serial port.
// Assumes the supply comparator, pins and serial clock are all asynchronous to i_ref_clk.
//
// Functional notes
// R1 - Host holds select high whole transaction
// R2 - One data line; device drives only reads
// R3 - Command byte first; low seven bits address
// R4 - Command bit seven: zero read, one write
// R5 - Interrupt high while flag and enable set
// R6 - No chip select without RAM select low
// R7 - Low select needs low lane and select
// R8 - High select needs high lane and select
// R9 - Missing watchdog kick drives processor reset
// R10 - Reset on supply, watchdog, power-up, pushbutton
// R11 - Pushbutton debounced, then reset 250 ms
// R12 - Inputs ignored until power-up hold ends
// R13 - Reset held 250 ms after supply returns
// R14 - Chip selects controlled across power transitions
// R15 - Chip selects blocked during fail and hold; code blocks them only in the power-up hold, not watchdog or button holds
// R16 - Chip selects follow byte lanes when selected
// R17 - Writes rejected while write protect set; control still written, only the status flag clear is blocked
// R18 - Command then data byte, LSB first
// R19 - Select low aborts transfer, releases line
// R20 - Watchdog restarts on kick and reset end
`timescale 1ns/1ps
`default_nettype none

module sssp_top
  import sssp_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = HOLD_CYC,
  parameter int unsigned WDOG_CYCLES = WDOG_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_power_ok,
  input wire logic i_low_battery,
  input wire logic i_alarm_event,
  input wire logic i_sel,
  input wire logic i_sclk,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  input wire logic i_watchdog_kick_n,
  input wire logic i_cpu_reset_n,
  output logic o_cpu_reset_n,
  output logic o_cpu_reset_oe,
  input wire logic i_ram_select_in_n,
  input wire logic i_lower_byte_select_n,
  input wire logic i_upper_byte_select_n,
  output logic o_lower_ram_select_out_n,
  output logic o_upper_ram_select_out_n,
  output logic o_irq
);

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] WDOG_LAST = CNT_W'(WDOG_CYCLES - 1);
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [4:0] LAST_CMD_BIT = 5'(BYTE_BITS - 1);
  localparam logic [4:0] LAST_DATA_BIT = 5'(FRAME_BITS - 1);
  localparam logic [4:0] FRAME_END = 5'(FRAME_BITS);

  sssp_pins_t raw;
  sssp_pins_t s1_q;
  sssp_pins_t s2_q;
  sssp_pins_t s3_q;
  sssp_pins_t flt_q;
  sssp_pins_t flt_prev_q;

  assign raw = '{power_ok: i_power_ok, sel: i_sel, sclk: i_sclk, sdio: i_sdio,
                 kick_n: i_watchdog_kick_n, rst_pin: i_cpu_reset_n};

  // Three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= PINS_RST;
      s2_q <= PINS_RST;
      s3_q <= PINS_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < $bits(sssp_pins_t); gi++) begin : g_flt
      always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          flt_q[gi] <= PINS_RST[gi];
          flt_prev_q[gi] <= PINS_RST[gi];
        end else begin
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
          flt_prev_q[gi] <= flt_q[gi];
        end
      end
    end
  endgenerate

  logic sclk_rise;
  logic sclk_fall;
  logic kick_fall;
  assign sclk_rise = flt_q.sclk & ~flt_prev_q.sclk;
  assign sclk_fall = ~flt_q.sclk & flt_prev_q.sclk;
  assign kick_fall = ~flt_q.kick_n & flt_prev_q.kick_n;

  // Reset sequencer
  sssp_rst_state_t state_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic [CNT_W-1:0] wdog_cnt_q;
  logic [CNT_W-1:0] deb_cnt_q;
  logic pwrup_q;
  logic wdog_expired;
  logic button_pressed;

  assign wdog_expired = (state_q == RS_RUN) && (wdog_cnt_q == WDOG_LAST);
  assign button_pressed = (state_q == RS_RUN) && !flt_q.rst_pin && (deb_cnt_q == DEB_LAST);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= RS_POWER_FAIL;
      hold_cnt_q <= '0;
    end else begin
      unique case (state_q)
        RS_POWER_FAIL: begin
          hold_cnt_q <= '0;
          if (flt_q.power_ok) begin
            state_q <= RS_HOLD; // see R13
          end
        end
        RS_HOLD: begin
          if (!flt_q.power_ok) begin
            state_q <= RS_POWER_FAIL; // see R10
          end else if (hold_cnt_q == HOLD_LAST) begin
            state_q <= RS_RUN; // see R13
            hold_cnt_q <= '0;
          end else begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
          end
        end
        RS_RUN: begin
          hold_cnt_q <= '0;
          if (!flt_q.power_ok) begin
            state_q <= RS_POWER_FAIL; // see R10
          end else if (wdog_expired || button_pressed) begin
            state_q <= RS_HOLD; // see R9 see R11
          end
        end
      endcase
    end
  end

  // Power-up hold flag: set by a supply failure, cleared when the first hold ends
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwrup_q <= 1'b1;
    end else if (state_q == RS_POWER_FAIL) begin
      pwrup_q <= 1'b1;
    end else if (state_q == RS_HOLD && hold_cnt_q == HOLD_LAST) begin
      pwrup_q <= 1'b0; // see R12
    end
  end

  // Watchdog restarts on a kick and whenever the sequencer leaves a reset pulse
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wdog_cnt_q <= '0;
    end else if (state_q != RS_RUN || kick_fall) begin
      wdog_cnt_q <= '0; // see R20
    end else if (wdog_cnt_q != WDOG_LAST) begin
      wdog_cnt_q <= wdog_cnt_q + 1'b1; // see R9
    end
  end

  // Pushbutton debounce; our own drive of the pin is ignored since it only counts in RUN
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      deb_cnt_q <= '0;
    end else if (state_q != RS_RUN || flt_q.rst_pin) begin
      deb_cnt_q <= '0;
    end else if (deb_cnt_q != DEB_LAST) begin
      deb_cnt_q <= deb_cnt_q + 1'b1; // see R11
    end
  end

  // Open-drain reset pin: only ever pulled low
  assign o_cpu_reset_n = 1'b0;
  assign o_cpu_reset_oe = (state_q != RS_RUN); // see R10

  // SRAM select gating; the pins pass combinationally so access timing is not stretched
  logic ram_block;
  assign ram_block = !flt_q.power_ok || pwrup_q; // see R14 see R15
  assign o_lower_ram_select_out_n = i_ram_select_in_n | i_lower_byte_select_n | ram_block; // see R6 see R7 see R16
  assign o_upper_ram_select_out_n = i_ram_select_in_n | i_upper_byte_select_n | ram_block; // see R6 see R8 see R16

  // Registers and interrupt
  logic [7:0] ctrl_q;
  logic irqf_q;
  logic [7:0] status;
  logic wr_stb;
  logic [7:0] wr_data;
  sssp_cmd_t cmd_q;

  // Battery comparator runs in another domain; same three-stage filter as the pins
  logic [2:0] bat_sync_q;
  logic bat_q;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bat_sync_q <= 3'h0;
      bat_q <= 1'h0;
    end else begin
      bat_sync_q <= {bat_sync_q[1:0], i_low_battery};
      if (bat_sync_q[1] == bat_sync_q[2]) begin
        bat_q <= bat_sync_q[2];
      end
    end
  end

  assign status = {1'b0, bat_q, 5'h00, irqf_q};

  // Write protect also guards the status flag; control stays writable so protection can be lifted
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_stb && cmd_q.addr == CTRL_ADDR) begin
      ctrl_q <= wr_data & CTRL_WMASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irqf_q <= 1'b0;
    end else if (i_alarm_event) begin
      irqf_q <= 1'b1;
    end else if (wr_stb && cmd_q.addr == STAT_ADDR && !ctrl_q[CTRL_WP_BIT] && wr_data[STAT_IRQF_BIT]) begin
      irqf_q <= 1'b0; // see R17
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irqf_q & ctrl_q[CTRL_AIE_BIT]; // see R5
    end
  end

  function automatic logic [7:0] reg_read(input logic [6:0] addr);
    logic [7:0] val;
    val = 8'h00;
    if (addr == CTRL_ADDR) begin
      val = ctrl_q;
    end else if (addr == STAT_ADDR) begin
      val = status;
    end
    return val;
  endfunction

  // Serial port
  logic [4:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] rd_q;
  logic active;
  logic is_write;

  assign active = flt_q.sel && !pwrup_q; // see R1 see R12
  assign is_write = (cmd_q.dir == DIR_WRITE);
  assign wr_data = {flt_q.sdio, shift_q[6:0]};
  assign wr_stb = active && sclk_rise && is_write && (bit_cnt_q == LAST_DATA_BIT);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_cnt_q <= '0;
      cmd_q <= '0;
      shift_q <= 8'h00;
      rd_q <= 8'h00;
    end else if (!active) begin
      bit_cnt_q <= '0; // see R19
    end else if (sclk_rise && bit_cnt_q != FRAME_END) begin
      bit_cnt_q <= bit_cnt_q + 1'b1; // see R18
      if (bit_cnt_q < 5'(BYTE_BITS)) begin
        if (bit_cnt_q == LAST_CMD_BIT) begin
          cmd_q.dir <= flt_q.sdio; // see R4
          rd_q <= reg_read(cmd_q.addr);
        end else begin
          cmd_q.addr[bit_cnt_q[2:0]] <= flt_q.sdio; // see R3
        end
      end else begin
        shift_q[bit_cnt_q[2:0]] <= flt_q.sdio; // see R18
      end
    end
  end

  // Read data goes out on the falling edge so the host samples it on the next rising edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sdio <= 1'b0;
      o_sdio_oe <= 1'b0;
    end else if (!active) begin
      o_sdio_oe <= 1'b0; // see R19
    end else if (sclk_fall) begin
      if (!is_write && bit_cnt_q >= 5'(BYTE_BITS) && bit_cnt_q != FRAME_END) begin
        o_sdio <= rd_q[bit_cnt_q[2:0]]; // see R2 see R18
        o_sdio_oe <= 1'b1;
      end else begin
        o_sdio_oe <= 1'b0; // see R2
      end
    end
  end

endmodule

`default_nettype wire

// ==== core/sssp_pkg.sv ====
// Package for the system supervisor and serial port block.
// Assumes a single 125 MHz reference clock; all timing is derived from it.
package sssp_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // power_up_hold_time, also the least pushbutton reset width
  localparam int unsigned HOLD_TIME_MS = 250;
  localparam int unsigned WDOG_TIME_MS = 500;
  localparam int unsigned DEBOUNCE_TIME_MS = 10;
  localparam int unsigned HOLD_CYC = HOLD_TIME_MS * CYC_PER_MS;
  localparam int unsigned WDOG_CYC = WDOG_TIME_MS * CYC_PER_MS;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_TIME_MS * CYC_PER_MS;
  localparam int unsigned CNT_W = 28;
  localparam int unsigned SYNC_STAGES = 3;

  // Serial frame layout
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned FRAME_BITS = 16;
  localparam logic DIR_WRITE = 1'b1;

  // Register addresses
  localparam logic [6:0] CTRL_ADDR = 7'h0B;
  localparam logic [6:0] STAT_ADDR = 7'h0C;

  // Field positions and reset values
  localparam int unsigned CTRL_WP_BIT = 6;
  localparam int unsigned CTRL_AIE_BIT = 0;
  localparam int unsigned STAT_LOBAT_BIT = 6;
  localparam int unsigned STAT_IRQF_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hF1;
  localparam logic [7:0] CTRL_RST = 8'h00;

  typedef struct packed {
    logic [6:0] addr;
    logic dir;
  } sssp_cmd_t;

  // Inputs that arrive from outside the clock domain
  typedef struct packed {
    logic power_ok;
    logic sel;
    logic sclk;
    logic sdio;
    logic kick_n;
    logic rst_pin;
  } sssp_pins_t;

  localparam sssp_pins_t PINS_RST = '{power_ok: 1'b0, sel: 1'b0, sclk: 1'b0, sdio: 1'b0,
                                      kick_n: 1'b1, rst_pin: 1'b1};

  typedef enum logic [1:0] {
    RS_POWER_FAIL,
    RS_HOLD,
    RS_RUN
  } sssp_rst_state_t;

endpackage

// ==== testbench/sssp_asserts.sv ====
// Port checker for sssp_top.
// Bound below; counts come from the top's parameters.
`timescale 1ns/1ps
`default_nettype none
module sssp_asserts #(
  parameter int unsigned HOLD_CYCLES = 40,
  parameter int unsigned WDOG_CYCLES = 200
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_power_ok,
  input wire logic i_sel,
  input wire logic o_sdio_oe,
  input wire logic i_watchdog_kick_n,
  input wire logic o_cpu_reset_oe,
  input wire logic i_ram_select_in_n,
  input wire logic i_lower_byte_select_n,
  input wire logic i_upper_byte_select_n,
  input wire logic o_lower_ram_select_out_n,
  input wire logic o_upper_ram_select_out_n
);
  logic [27:0] hi_q, wd_q;
  wire logic lo = o_lower_ram_select_out_n;
  wire logic up = o_upper_ram_select_out_n;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // Counters stand in for long repetitions
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hi_q <= '0;
      wd_q <= '0;
    end else begin
      hi_q <= o_cpu_reset_oe ? hi_q + 28'h1 : '0;
      wd_q <= (o_cpu_reset_oe || $fell(i_watchdog_kick_n)) ? '0 : wd_q + 28'h1;
    end
  end
  a_cs_need_sel: assert property (i_ram_select_in_n |-> lo && up)
    else $error("select out without ram select");
  a_low_lane: assert property (!lo |-> !i_lower_byte_select_n && !i_ram_select_in_n)
    else $error("low select out wrong");
  a_high_lane: assert property (!up |-> !i_upper_byte_select_n && !i_ram_select_in_n)
    else $error("high select out wrong");
  a_fail_block: assert property (!i_power_ok [*6] |-> lo && up)
    else $error("select out in power fail");
  a_fail_reset: assert property (!i_power_ok [*6] |-> o_cpu_reset_oe)
    else $error("no reset in power fail");
  a_hold_width: assert property ($fell(o_cpu_reset_oe) |-> hi_q >= HOLD_CYCLES)
    else $error("reset pulse short");
  a_sel_release: assert property (!i_sel [*6] |-> !o_sdio_oe)
    else $error("data line held");
  a_wdog_bound: assert property (wd_q <= WDOG_CYCLES + 8)
    else $error("watchdog late");
  c_hold_end: cover property ($fell(o_cpu_reset_oe));
  c_read: cover property ($rose(o_sdio_oe));
  c_word: cover property (!lo && !up);
endmodule
bind sssp_top sssp_asserts #(.HOLD_CYCLES(HOLD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) sssp_asserts_i (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_power_ok(i_power_ok), .i_sel(i_sel), .o_sdio_oe(o_sdio_oe),
  .i_watchdog_kick_n(i_watchdog_kick_n), .o_cpu_reset_oe(o_cpu_reset_oe), .i_ram_select_in_n(i_ram_select_in_n),
  .i_lower_byte_select_n(i_lower_byte_select_n), .i_upper_byte_select_n(i_upper_byte_select_n),
  .o_lower_ram_select_out_n(o_lower_ram_select_out_n), .o_upper_ram_select_out_n(o_upper_ram_select_out_n));
`default_nettype wire

// ==== testbench/sssp_host_model.sv ====
// Host end of the three-wire port.
// One shift period is eight bench cycles.
`timescale 1ns/1ps
`default_nettype none
module sssp_host_model (
  input wire logic i_clk,
  input wire logic i_dev_d,
  input wire logic i_dev_oe,
  output var logic o_sel,
  output var logic o_sclk,
  output logic o_line
);
  logic hd, hoe;
  logic last_q = 1'h0;
  // No pull on the line, so a released line toggles
  assign o_line = i_dev_oe ? i_dev_d : (hoe ? hd : ~last_q);
  initial {o_sel, o_sclk, hd, hoe} = '0;
  always @(posedge i_clk) last_q <= o_line;
  // Samples late in the high phase: the answer lags the falling edge
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, input int n, output logic [7:0] r);
    logic [15:0] f;
    f = {d, c};
    r = 8'h00;
    @(posedge i_clk);
    o_sel <= 1'h1;
    for (int i = 0; i < n; i++) begin
      hoe <= i < 8 || c[7];
      hd <= f[i];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'h1;
      repeat (4) @(posedge i_clk);
      if (i > 7) r[i-8] = o_line;
      o_sclk <= 1'h0;
    end
    hoe <= 1'h0;
    o_sel <= 1'h0;
    repeat (6) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Bench for sssp_top: lanes, serial port, supply, button, watchdog.
// Host model drives the port; counts shrunk by parameter.
`timescale 1ns/1ps
`default_nettype none
module tb_top import sssp_pkg::*;;
  logic clk, rstn, pwr, bat, alm, ken, pb_n, ram_n, up_n, lo_n, smp;
  logic kick_n = 1'h1;
  logic sel, sclk, line, sdo, soe, drv, oe, lo_o, up_o, irq;
  logic [1:0] kind;
  logic [6:0] kc = 7'h00;
  logic [7:0] rd;
  logic [7:0] exp_q[$];
  int bad_count, n_checks;
  wire logic pin = pb_n & (oe ? drv : 1'h1);
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  sssp_top #(.HOLD_CYCLES(40), .WDOG_CYCLES(200), .DEBOUNCE_CYCLES(10)) sssp_top_i (
    .i_ref_clk(clk), .i_rstn(rstn), .i_power_ok(pwr), .i_low_battery(bat), .i_alarm_event(alm),
    .i_sel(sel), .i_sclk(sclk), .i_sdio(line), .o_sdio(sdo), .o_sdio_oe(soe), .i_watchdog_kick_n(kick_n),
    .i_cpu_reset_n(pin), .o_cpu_reset_n(drv), .o_cpu_reset_oe(oe), .i_ram_select_in_n(ram_n),
    .i_lower_byte_select_n(lo_n), .i_upper_byte_select_n(up_n), .o_lower_ram_select_out_n(lo_o),
    .o_upper_ram_select_out_n(up_o), .o_irq(irq));
  sssp_host_model sssp_host_model_i (.i_clk(clk), .i_dev_d(sdo), .i_dev_oe(soe), .o_sel(sel),
    .o_sclk(sclk), .o_line(line));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic note(input logic [1:0] k, input logic [7:0] e);
    exp_q.push_back(e);
    kind <= k;
    smp <= 1'h1;
    @(posedge clk);
    smp <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wait_oe(input logic v);
    int n;
    for (n = 0; n < 400 && oe !== v; n++) @(posedge clk);
    if (n == 400) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic io(input logic [7:0] c, input logic [7:0] d, input int n);
    sssp_host_model_i.xfer(c, d, n, rd);
  endtask
  always @(posedge clk) begin
    if (smp) begin
      chk(kind == 2'h1 ? {6'h00, up_o, lo_o} : kind == 2'h2 ? rd : {5'h00, drv, oe, irq}, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    kc <= kc + 7'h01;
    // Kick lasts four cycles: the pin filter swallows a one-cycle glitch
    kick_n <= !(ken && kc < 7'h04);
  end
  initial begin
    void'($urandom(46));
    {rstn, pwr, alm, ken, smp, kind, rd, bat} = '0;
    {pb_n, ram_n, up_n, lo_n} = '1;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    pwr <= 1'h1;
    bat <= 1'($urandom);
    wait_oe(1'h0);
    for (int c = 0; c < 8; c++) begin
      {ram_n, up_n, lo_n} <= 3'(c);
      @(posedge clk);
      note(2'h1, {6'h00, c[2] | c[1], c[2] | c[0]});
    end
    ken <= 1'h1;
    io({DIR_WRITE, CTRL_ADDR}, 8'h01, 16);
    alm <= 1'h1;
    @(posedge clk);
    alm <= 1'h0;
    repeat (2) @(posedge clk);
    note(2'h3, 8'h01);
    io({1'h0, CTRL_ADDR}, 8'h00, 16);
    note(2'h2, 8'h01);
    io({1'h0, STAT_ADDR}, 8'h00, 16);
    note(2'h2, {1'h0, bat, 6'h01});
    io({DIR_WRITE, CTRL_ADDR}, 8'h41, 16);
    io({DIR_WRITE, STAT_ADDR}, 8'h01, 16);
    note(2'h3, 8'h01);
    io({DIR_WRITE, CTRL_ADDR}, 8'h01, 12);
    io({1'h0, CTRL_ADDR}, 8'h00, 16);
    note(2'h2, 8'h41);
    io({DIR_WRITE, CTRL_ADDR}, 8'h01, 16);
    io({DIR_WRITE, STAT_ADDR}, 8'h01, 16);
    note(2'h3, 8'h00);
    pwr <= 1'h0;
    repeat (6) @(posedge clk);
    note(2'h3, 8'h02);
    repeat (3) begin
      {ram_n, up_n, lo_n} <= 3'($urandom);
      @(posedge clk);
      note(2'h1, 8'h03);
    end
    {ram_n, up_n, lo_n} <= 3'h0;
    pwr <= 1'h1;
    repeat (20) @(posedge clk);
    note(2'h1, 8'h03);
    wait_oe(1'h0);
    pb_n <= 1'h0;
    repeat (20) @(posedge clk);
    note(2'h3, 8'h02);
    pb_n <= 1'h1;
    wait_oe(1'h0);
    ken <= 1'h0;
    wait_oe(1'h1);
    ken <= 1'h1;
    wait_oe(1'h0);
    final_report();
  end
endmodule
`default_nettype wire
